//--- gpsi_clk_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module gpsi_clk_monitor (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic gpsi_rx_clk_pin,
  input  wire logic rx_clk_substitute,
  output logic      rx_clk_stopped,
  output logic      use_tx_clk
);
  logic       s1_q, s2_q, s3_q, filt_q;
  logic [4:0] idle_q;

  // Three-stage sync; level accepted once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      filt_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= gpsi_rx_clk_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        filt_q <= s3_q;
      end
    end
  end

  wire logic rx_edge = (s2_q == s3_q) && (s3_q != filt_q);
  wire logic stop_d  = (idle_q == switch_qos_pkg::RX_STOP_CYCLES);

  // Idle counter saturates; stop is seen only after a long quiet spell
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_q         <= 5'h00;
      rx_clk_stopped <= 1'b0;
      use_tx_clk     <= 1'b0;
    end else if (clk_en) begin
      if (rx_edge) begin
        idle_q <= 5'h00;
      end else if (!stop_d) begin
        idle_q <= idle_q + 5'h01;
      end
      rx_clk_stopped <= stop_d & ~rx_edge;
      use_tx_clk     <= rx_clk_substitute & stop_d & ~rx_edge;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_no_sub_when_off;
    clk_en && !rx_clk_substitute |=> !use_tx_clk;
  endproperty
  a_no_sub_when_off: assert property (p_no_sub_when_off) else $error("substitution while off");

  property p_sub_when_stopped;
    clk_en && rx_clk_substitute && stop_d && !rx_edge |=> use_tx_clk;
  endproperty
  a_sub_when_stopped: assert property (p_sub_when_stopped) else $error("no substitution");
endmodule // gpsi_clk_monitor
`default_nettype wire

//--- switch_qos_control_regs.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module switch_qos_control_regs (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Packet classification
  input  wire logic        pkt_valid,
  input  wire logic        pkt_tagged_ipv4,
  input  wire logic [7:0]  pkt_tos,
  input  wire logic        pkt_is_bcast,
  input  wire logic        pkt_is_mcast,
  output logic             q_valid,
  output logic [1:0]       q_sel,
  output logic [1:0]       q_drop_scheme,
  output logic             storm_count_inc,
  // Serial port receive clock
  input  wire logic        gpsi_rx_clk_pin,
  output logic             rx_clk_stopped,
  output logic             use_tx_clk,
  // Control levels
  output logic             crc_check_en,
  output logic             backoff_en,
  output logic             legacy_storm_protect_en,
  output logic [1:0]       legacy_storm_threshold,
  output logic             cpu_port_present,
  output logic [5:0]       cpu_port_map
);
  logic [15:0] tos_queue_map_q;
  logic [15:0] system_control_two_q;
  logic [2:0]  cpu_port_number_q;
  logic [31:0] prdata_q;
  logic        storm_inc_q;
  logic        crc_en_q;
  logic        backoff_en_q;
  logic        cpu_present_q;
  logic [5:0]  cpu_map_q;

  // Address decode
  wire logic hit_tos  = (paddr == switch_qos_pkg::TOS_MAP_ADDR);
  wire logic hit_sys  = (paddr == switch_qos_pkg::SYS_CTRL_ADDR);
  wire logic hit_cpu  = (paddr == switch_qos_pkg::CPU_PORT_ADDR);
  wire logic hit_any  = hit_tos | hit_sys | hit_cpu;
  wire logic setup    = psel & ~penable & clk_en;
  wire logic access   = psel & penable & clk_en;
  wire logic wr_ok    = access & pwrite & hit_any;

  // Bus answers in the first access cycle unless the core is frozen
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;

  // Fields of system control two
  wire logic        aging_off         = system_control_two_q[switch_qos_pkg::AGING_OFF_BIT];
  wire logic        rx_clk_substitute = system_control_two_q[switch_qos_pkg::RX_CLK_SUB_BIT];
  wire logic        storm_count_multicast = system_control_two_q[switch_qos_pkg::STORM_MCAST_BIT];
  wire logic        crc_check_off     = system_control_two_q[switch_qos_pkg::CRC_OFF_BIT];
  wire logic        backoff_off       = system_control_two_q[switch_qos_pkg::BACKOFF_OFF_BIT];
  wire logic [7:0]  drop_schemes      =
    system_control_two_q[switch_qos_pkg::DROP_Q0_LSB +: switch_qos_pkg::DROP_W];

  // Read mux, unmapped and reserved bits read zero
  wire logic [15:0] cpu_word   = {cpu_port_number_q, 13'h0000};
  wire logic [15:0] rd_word    = hit_tos ? tos_queue_map_q :
                                 hit_sys ? system_control_two_q :
                                 hit_cpu ? cpu_word : 16'h0000;

  // Register file; write lands on the access edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tos_queue_map_q      <= switch_qos_pkg::TOS_MAP_RESET;
      system_control_two_q <= switch_qos_pkg::SYS_CTRL_RESET;
      cpu_port_number_q    <= switch_qos_pkg::CPU_PORT_RESET;
    end else if (wr_ok) begin
      if (hit_tos) begin
        tos_queue_map_q <= pwdata[15:0];
      end
      if (hit_sys) begin
        system_control_two_q <= pwdata[15:0];
      end
      if (hit_cpu) begin
        cpu_port_number_q <= pwdata[15:switch_qos_pkg::CPU_PORT_LSB];
      end
    end
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {16'h0000, rd_word};
    end
  end

  // CPU port decode; 110 and 111 are both out of port range
  logic [5:0] cpu_map_d;
  genvar gi;
  generate
    for (gi = 0; gi < switch_qos_pkg::NUM_PORTS; gi++) begin : g_cpu
      assign cpu_map_d[gi] = (cpu_port_number_q == 3'(gi));
    end
  endgenerate
  wire logic cpu_present_d = (cpu_port_number_q <= switch_qos_pkg::CPU_PORT_LAST);

  // Storm event qualifier: multicast only when enabled
  wire logic storm_hit = pkt_valid & (pkt_is_bcast | (pkt_is_mcast & storm_count_multicast));

  // Control levels and storm pulse, registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      storm_inc_q   <= 1'b0;
      crc_en_q      <= 1'b1;
      backoff_en_q  <= 1'b1;
      cpu_present_q <= 1'b0;
      cpu_map_q     <= 6'h00;
    end else if (clk_en) begin
      storm_inc_q   <= storm_hit;
      crc_en_q      <= ~crc_check_off;
      backoff_en_q  <= ~backoff_off;
      cpu_present_q <= cpu_present_d;
      cpu_map_q     <= cpu_map_d;
    end
  end

  assign storm_count_inc         = storm_inc_q;
  assign crc_check_en            = crc_en_q;
  assign backoff_en              = backoff_en_q;
  assign cpu_port_present        = cpu_present_q;
  assign cpu_port_map            = cpu_map_q;
  // Legacy storm fields go straight from the register
  assign legacy_storm_protect_en = system_control_two_q[switch_qos_pkg::LEGACY_STORM_BIT];
  assign legacy_storm_threshold  =
    system_control_two_q[switch_qos_pkg::THRESH_LSB +: switch_qos_pkg::THRESH_W];

  // Queue map and drop scheme lookup
  tos_classifier u_classifier (
    .clock           (clock),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .pkt_valid       (pkt_valid),
    .pkt_tagged_ipv4 (pkt_tagged_ipv4),
    .pkt_tos         (pkt_tos),
    .tos_queue_map   (tos_queue_map_q),
    .drop_schemes    (drop_schemes),
    .q_valid         (q_valid),
    .q_sel           (q_sel),
    .q_drop_scheme   (q_drop_scheme)
  );

  // Receive clock watch; the clock itself is only sampled as data
  gpsi_clk_monitor u_clk_monitor (
    .clock             (clock),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .gpsi_rx_clk_pin   (gpsi_rx_clk_pin),
    .rx_clk_substitute (rx_clk_substitute),
    .rx_clk_stopped    (rx_clk_stopped),
    .use_tx_clk        (use_tx_clk)
  );

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_sys_write_bit(int b, bit v);
    clk_en && psel && penable && pwrite && hit_sys && pwdata[b] == v;
  endsequence

  property p_aging_stored;
    logic v;
    (wr_ok && hit_sys, v = pwdata[7]) ##1 (psel && !penable && hit_sys && clk_en)
      |=> (prdata[7] == v);
  endproperty
  a_aging_stored: assert property (p_aging_stored) else $error("aging bit not kept");

  // Only the aging bit of bits 7:0 flips, so crc_check_en and backoff_en must hold still
  property p_aging_no_effect;
    clk_en && wr_ok && hit_sys && (pwdata[7] != aging_off)
      && (pwdata[6:0] == system_control_two_q[6:0])
      |=> ##1 $stable(crc_check_en) && $stable(backoff_en);
  endproperty
  a_aging_no_effect: assert property (p_aging_no_effect) else $error("aging bit drove logic");

  property p_storm_mcast;
    clk_en && pkt_valid && pkt_is_mcast && !pkt_is_bcast
      |=> (storm_count_inc == $past(storm_count_multicast));
  endproperty
  a_storm_mcast: assert property (p_storm_mcast) else $error("multicast storm count wrong");

  property p_storm_bcast;
    clk_en && pkt_valid && pkt_is_bcast |=> storm_count_inc;
  endproperty
  a_storm_bcast: assert property (p_storm_bcast) else $error("broadcast not counted");

  property p_crc_off;
    s_sys_write_bit(switch_qos_pkg::CRC_OFF_BIT, 1'b1) ##1 clk_en |=> !crc_check_en;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc check still on");

  property p_backoff_on;
    s_sys_write_bit(switch_qos_pkg::BACKOFF_OFF_BIT, 1'b0) ##1 clk_en |=> backoff_en;
  endproperty
  a_backoff_on: assert property (p_backoff_on) else $error("back-off not enabled");

  property p_legacy_en;
    s_sys_write_bit(switch_qos_pkg::LEGACY_STORM_BIT, 1'b1) |=> legacy_storm_protect_en;
  endproperty
  a_legacy_en: assert property (p_legacy_en) else $error("storm protect not enabled");

  property p_threshold;
    logic [1:0] t;
    (wr_ok && hit_sys, t = pwdata[1:0]) |=> (legacy_storm_threshold == t);
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold not applied");

  property p_cpu_port;
    logic [2:0] n;
    (wr_ok && hit_cpu && pwdata[15:13] <= 3'h5, n = pwdata[15:13]) ##1 clk_en
      |=> cpu_port_present && (cpu_port_map == (6'h01 << n));
  endproperty
  a_cpu_port: assert property (p_cpu_port) else $error("cpu port decode wrong");

  property p_cpu_none;
    (wr_ok && hit_cpu && pwdata[15:14] == 2'h3) ##1 clk_en
      |=> !cpu_port_present && cpu_port_map == 6'h00;
  endproperty
  a_cpu_none: assert property (p_cpu_none) else $error("no-cpu value misread");
endmodule // switch_qos_control_regs
`default_nettype wire

//--- switch_qos_pkg.sv
`default_nettype none
package switch_qos_pkg;
  // Register word offsets on the APB
  localparam logic [7:0]  TOS_MAP_ADDR      = 8'h00;
  localparam logic [7:0]  SYS_CTRL_ADDR     = 8'h04;
  localparam logic [7:0]  CPU_PORT_ADDR     = 8'h08;
  localparam int          REG_W             = 16;

  // Reset values
  localparam logic [15:0] TOS_MAP_RESET     = 16'h0000;
  localparam logic [15:0] SYS_CTRL_RESET    = 16'h0040;
  localparam logic [2:0]  CPU_PORT_RESET    = 3'h7;

  // System control two, field positions
  localparam int          DROP_Q0_LSB       = 8;
  localparam int          DROP_W            = 8;
  localparam int          AGING_OFF_BIT     = 7;
  localparam int          RX_CLK_SUB_BIT    = 6;
  localparam int          STORM_MCAST_BIT   = 5;
  localparam int          CRC_OFF_BIT       = 4;
  localparam int          BACKOFF_OFF_BIT   = 3;
  localparam int          LEGACY_STORM_BIT  = 2;
  localparam int          THRESH_LSB        = 0;
  localparam int          THRESH_W          = 2;

  // CPU port field
  localparam int          CPU_PORT_LSB      = 13;
  localparam int          CPU_PORT_W        = 3;
  localparam int          NUM_PORTS         = 6;
  localparam logic [2:0]  CPU_PORT_LAST     = 3'h5;

  // TOS index and queue fields
  localparam int          TOS_IDX_LSB       = 5;
  localparam int          QSEL_W            = 2;

  // Receive clock idle cycles before it counts as stopped
  localparam logic [4:0]  RX_STOP_CYCLES    = 5'h10;
endpackage
`default_nettype wire

//--- tb_switch_qos_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_switch_qos_control_regs;
  logic        clock, rst_n, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr, pkt_tos;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pkt_valid, pkt_tagged_ipv4, pkt_is_bcast, pkt_is_mcast;
  logic        q_valid, storm_count_inc, gpsi_rx_clk_pin, rx_clk_stopped, use_tx_clk;
  logic [1:0]  q_sel, q_drop_scheme, legacy_storm_threshold;
  logic        crc_check_en, backoff_en, legacy_storm_protect_en, cpu_port_present, err;
  logic [5:0]  cpu_port_map;
  int          error_cnt, samples_checked;

  switch_qos_control_regs DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
    .pkt_tagged_ipv4(pkt_tagged_ipv4), .pkt_tos(pkt_tos), .pkt_is_bcast(pkt_is_bcast),
    .pkt_is_mcast(pkt_is_mcast), .q_valid(q_valid), .q_sel(q_sel),
    .q_drop_scheme(q_drop_scheme), .storm_count_inc(storm_count_inc),
    .gpsi_rx_clk_pin(gpsi_rx_clk_pin), .rx_clk_stopped(rx_clk_stopped),
    .use_tx_clk(use_tx_clk), .crc_check_en(crc_check_en), .backoff_en(backoff_en),
    .legacy_storm_protect_en(legacy_storm_protect_en),
    .legacy_storm_threshold(legacy_storm_threshold), .cpu_port_present(cpu_port_present),
    .cpu_port_map(cpu_port_map));

  // Free-running core clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    samples_checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("mismatch at %0t exp %h got %h", $time, exp, act);
    end
  endtask

  // One APB transfer; waits on pready, bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 20) begin
        error_cnt++;
        results();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One packet pulse; returns the pulses seen one edge later
  task automatic pkt(input logic tg, input logic [7:0] tos, input logic bc, input logic mc,
                     output logic qv, output logic si);
    @(posedge clock);
    pkt_valid <= 1'b1; pkt_tagged_ipv4 <= tg; pkt_tos <= tos;
    pkt_is_bcast <= bc; pkt_is_mcast <= mc;
    @(posedge clock);
    pkt_valid <= 1'b0;
    #1;
    qv = q_valid;
    si = storm_count_inc;
  endtask

  // Wait for rx_clk_stopped to reach a level, bounded
  task automatic wait_stop(input logic lvl);
    int n;
    n = 0;
    while (rx_clk_stopped !== lvl) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 80) begin
        error_cnt++;
        results();
      end
    end
    #1;
  endtask

  task automatic test_reset();
    apb(1'b0, switch_qos_pkg::TOS_MAP_ADDR, 32'h0);
    chk(32'h00000000, rd);
    apb(1'b0, switch_qos_pkg::SYS_CTRL_ADDR, 32'h0);
    chk(32'h00000040, rd);
    apb(1'b0, switch_qos_pkg::CPU_PORT_ADDR, 32'h0);
    chk(32'h0000e000, rd);
    chk({30'h0, crc_check_en, backoff_en}, 32'h3);
    chk({31'h0, cpu_port_present}, 32'h0);
    apb(1'b1, 8'h0c, 32'h0000ffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
  endtask

  // Every TOS index against a map and per-queue drop schemes
  task automatic test_tos();
    logic        qv, si;
    logic [15:0] map;
    logic [1:0]  q;
    map = 16'h1be4;
    apb(1'b1, switch_qos_pkg::TOS_MAP_ADDR, {16'h0, map});
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h00001b40);
    for (int i = 0; i < 8; i++) begin
      q = map[2*i +: 2];
      pkt(1'b1, {i[2:0], 5'h15}, 1'b0, 1'b0, qv, si);
      chk({31'h0, qv}, 32'h1);
      chk({30'h0, q_sel}, {30'h0, q});
      chk({30'h0, q_drop_scheme}, {30'h0, 2'(8'h1b >> (2*q))});
    end
    pkt(1'b0, 8'he0, 1'b0, 1'b0, qv, si);
    chk({31'h0, qv}, 32'h0);
    $display("test tos done");
  endtask

  // Control levels and storm counter scope
  task automatic test_ctrl();
    logic qv, si;
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h000000da);
    @(posedge clock);
    #1;
    chk({28'h0, crc_check_en, backoff_en, legacy_storm_threshold}, 32'h2);
    chk({31'h0, legacy_storm_protect_en}, 32'h0);
    // Flip only the aging bit; no derived level may move
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h0000005a);
    repeat (2) @(posedge clock);
    #1;
    chk(32'h2, {28'h0, crc_check_en, backoff_en, legacy_storm_threshold});
    pkt(1'b0, 8'h0, 1'b0, 1'b1, qv, si);
    chk({31'h0, si}, 32'h0);
    pkt(1'b0, 8'h0, 1'b1, 1'b0, qv, si);
    chk({31'h0, si}, 32'h1);
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h000000a5);
    @(posedge clock);
    #1;
    chk({28'h0, crc_check_en, backoff_en, legacy_storm_threshold}, 32'hd);
    chk({31'h0, legacy_storm_protect_en}, 32'h1);
    pkt(1'b0, 8'h0, 1'b0, 1'b1, qv, si);
    chk({31'h0, si}, 32'h1);
    apb(1'b0, switch_qos_pkg::SYS_CTRL_ADDR, 32'h0);
    chk(32'h000000a5, rd);
    $display("test ctrl done");
  endtask

  // All eight CPU port codes
  task automatic test_cpu();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, switch_qos_pkg::CPU_PORT_ADDR, {16'h0, i[2:0], 13'h0});
      @(posedge clock);
      #1;
      chk({31'h0, cpu_port_present}, {31'h0, i < 6});
      chk({26'h0, cpu_port_map}, (i < 6) ? (32'h1 << i) : 32'h0);
    end
    $display("test cpu done");
  endtask

  task automatic toggle_rx(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clock);
      gpsi_rx_clk_pin <= ~gpsi_rx_clk_pin;
    end
  endtask

  // Receive clock stop with and without substitution
  task automatic test_rxclk();
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h00000040);
    toggle_rx(10);
    wait_stop(1'b1);
    chk({31'h0, use_tx_clk}, 32'h1);
    toggle_rx(4);
    wait_stop(1'b0);
    @(posedge clock);
    #1;
    chk({31'h0, use_tx_clk}, 32'h0);
    apb(1'b1, switch_qos_pkg::SYS_CTRL_ADDR, 32'h00000000);
    wait_stop(1'b1);
    repeat (3) @(posedge clock);
    #1;
    chk({31'h0, use_tx_clk}, 32'h0);
    $display("test rxclk done");
  endtask

  // Reset, then each scenario in turn
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pkt_valid = 1'b0; pkt_tagged_ipv4 = 1'b0;
    pkt_tos = 8'h00; pkt_is_bcast = 1'b0; pkt_is_mcast = 1'b0; gpsi_rx_clk_pin = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_tos();
    test_ctrl();
    test_cpu();
    test_rxclk();
    results();
  end
endmodule // tb_switch_qos_control_regs
`default_nettype wire

//--- tos_classifier.sv
`timescale 1ns/10ps
`default_nettype none
module tos_classifier (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       pkt_valid,
  input  wire logic       pkt_tagged_ipv4,
  input  wire logic [7:0] pkt_tos,
  input  wire logic [15:0] tos_queue_map,
  input  wire logic [7:0] drop_schemes,
  output logic            q_valid,
  output logic [1:0]      q_sel,
  output logic [1:0]      q_drop_scheme
);
  // Top three TOS bits pick a 2-bit field of the map
  wire logic [2:0] tos_idx    = pkt_tos[7:switch_qos_pkg::TOS_IDX_LSB];
  wire logic       classify   = pkt_valid & pkt_tagged_ipv4 & clk_en;
  wire logic [1:0] sel_d      = tos_queue_map[{tos_idx, 1'b0} +: switch_qos_pkg::QSEL_W];
  wire logic [1:0] drop_d     = drop_schemes[{sel_d, 1'b0} +: switch_qos_pkg::QSEL_W];

  // Registered classification result
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_valid       <= 1'b0;
      q_sel         <= 2'h0;
      q_drop_scheme <= 2'h0;
    end else if (clk_en) begin
      q_valid       <= classify;
      if (classify) begin
        q_sel         <= sel_d;
        q_drop_scheme <= drop_d;
      end
    end
  end

  // Independent shift-based model for checking
  wire logic [15:0] map_shift  = tos_queue_map >> {tos_idx, 1'b0};
  wire logic [7:0]  drop_shift = drop_schemes >> {map_shift[1:0], 1'b0};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_tos_map;
    logic [1:0] exp;
    (classify, exp = map_shift[1:0]) |=> (q_valid && q_sel == exp);
  endproperty
  a_tos_map: assert property (p_tos_map) else $error("queue select wrong");

  property p_drop_scheme;
    logic [1:0] exp;
    (classify, exp = drop_shift[1:0]) |=> (q_drop_scheme == exp);
  endproperty
  a_drop_scheme: assert property (p_drop_scheme) else $error("drop scheme wrong");
endmodule // tos_classifier
`default_nettype wire
